// file: hdl/ebm_pkg.sv
// constants, types and helpers for the embedded block memory
// How it works
// - shapes 8192x1, 4096x2, 2048x4 and 1024x9 offered in every mode.
// - the 512x18 shape exists only in pseudo dual-port, rom and fifo modes.
// - each port of a multi-port mode picks its own width.
// - bits run word 0 lsb to msb, then word 1; same for all ports.
// - the array may be preloaded at configuration from the user flash store.
// - an all-zero image reads nothing from the user flash store.
// - instances with the same image base share one stored image.
// - port write data and address pass input registers before the array; fifo writes take din_a directly.
// - port read data leave directly or through an optional output register.
// - global_set_reset acts asynchronously when gsr_en is set or in fifo mode.
// - fifo mode always honours global_set_reset; its enables act as clock enables.
// - fifo full reset and read_pointer_clear act asynchronously.
// - synchronous reset with global_set_reset disabled needs no ordering.
package ebm_pkg;
  localparam int MEM_BITS = 9216;
  localparam int IDX_W = 14;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 18;
  localparam int REG_AW = 3;
  localparam int REG_DW = 16;
  localparam int LOAD_W = 16;
  localparam int LOAD_WORDS = 576;
  localparam int LOAD_IDX_W = 10;
  localparam int FLASH_AW = 16;
  localparam logic [IDX_W-1:0] MEM_LIM = 14'h2400;
  localparam logic [IDX_W-1:0] CAP_POW2 = 14'h2000;
  localparam logic [ADDR_W-1:0] DEPTH_MASK = 13'h1fff;
  localparam logic [4:0] LOAD_BITS = 5'h10;
  localparam logic [LOAD_IDX_W-1:0] LOAD_LAST = 10'h23f;
  // width codes
  localparam logic [2:0] WC_X1 = 3'h0;
  localparam logic [2:0] WC_X2 = 3'h1;
  localparam logic [2:0] WC_X4 = 3'h2;
  localparam logic [2:0] WC_X9 = 3'h3;
  localparam logic [2:0] WC_X18 = 3'h4;
  typedef enum logic [2:0] {
    MODE_SP = 3'h0,
    MODE_TDP = 3'h1,
    MODE_PDP = 3'h2,
    MODE_ROM = 3'h3,
    MODE_FIFO = 3'h4
  } mode_t;
  // register offsets and fields
  localparam logic [REG_AW-1:0] REG_CTRL = 3'h0;
  localparam logic [REG_AW-1:0] REG_WIDTH = 3'h1;
  localparam logic [REG_AW-1:0] REG_IMAGE = 3'h2;
  localparam logic [REG_AW-1:0] REG_START = 3'h3;
  localparam logic [REG_AW-1:0] REG_STATUS = 3'h4;
  localparam logic [REG_AW-1:0] REG_LEVEL = 3'h5;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_OREG_A = 3;
  localparam int CTRL_OREG_B = 4;
  localparam int CTRL_GSR_EN = 5;
  localparam int CTRL_ZERO = 6;
  localparam int WIDTH_A_LSB = 0;
  localparam int WIDTH_B_LSB = 4;
  localparam int START_GO = 0;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_CFG_ERR = 2;
  localparam int ST_FULL = 3;
  localparam int ST_EMPTY = 4;
  localparam logic [REG_DW-1:0] CTRL_RESET = 16'h0000;
  localparam logic [REG_DW-1:0] WIDTH_RESET = 16'h0000;
  localparam logic [FLASH_AW-1:0] IMAGE_RESET = 16'h0000;

  function automatic logic [4:0] width_of(input logic [2:0] code);
    unique case (code)
      WC_X1: return 5'h01;
      WC_X2: return 5'h02;
      WC_X4: return 5'h04;
      WC_X9: return 5'h09;
      WC_X18: return 5'h12;
      default: return 5'h01;
    endcase
  endfunction

  // linear bit address of a word, same layout for every width
  function automatic logic [IDX_W-1:0] bit_base(input logic [ADDR_W-1:0] addr,
                                                input logic [2:0] code);
    logic [17:0] prod;
    prod = 18'(addr & (DEPTH_MASK >> code)) * 18'(width_of(code));
    return prod[IDX_W-1:0];
  endfunction

  // add with wrap at lim; top bit tells a wrap happened
  function automatic logic [IDX_W:0] advance(input logic [IDX_W-1:0] p,
                                             input logic [4:0] n,
                                             input logic [IDX_W-1:0] lim);
    logic [IDX_W:0] s;
    s = {1'b0, p} + (IDX_W + 1)'(n);
    if (s >= {1'b0, lim}) return {1'b1, s[IDX_W-1:0] - lim};
    return {1'b0, s[IDX_W-1:0]};
  endfunction

  function automatic logic [DATA_W-1:0] read_bits(input logic [MEM_BITS-1:0] m,
      input logic [IDX_W-1:0] base, input logic [4:0] n, input logic [IDX_W-1:0] lim);
    logic [DATA_W-1:0] r;
    logic [IDX_W:0] a;
    r = '0;
    for (int i = 0; i < DATA_W; i++) begin
      a = advance(base, 5'(i), lim);
      if (5'(i) < n) r[i] = m[a[IDX_W-1:0]];
    end
    return r;
  endfunction

  function automatic logic [MEM_BITS-1:0] write_bits(input logic [MEM_BITS-1:0] m,
      input logic [IDX_W-1:0] base, input logic [DATA_W-1:0] d, input logic [4:0] n,
      input logic [IDX_W-1:0] lim);
    logic [MEM_BITS-1:0] r;
    logic [IDX_W:0] a;
    r = m;
    for (int i = 0; i < DATA_W; i++) begin
      a = advance(base, 5'(i), lim);
      if (5'(i) < n) r[a[IDX_W-1:0]] = d[i];
    end
    return r;
  endfunction

  function automatic logic legal(input mode_t mode, input logic [2:0] code);
    if (code > WC_X18) return 1'b0;
    if (mode > MODE_FIFO) return 1'b0;
    if (code == WC_X18 && (mode == MODE_SP || mode == MODE_TDP)) return 1'b0;
    return 1'b1;
  endfunction
endpackage

// file: hdl/ebm_port.sv
// one memory port: input registers and optional output register
module ebm_port
  import ebm_pkg::*;
(
  // clock and resets
  input wire logic clk,
  input wire logic reset,
  input wire logic sync_reset,
  // user side
  input wire logic ce,
  input wire logic we,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] din,
  output logic [DATA_W-1:0] dout,
  // array side
  input wire logic out_reg_en,
  input wire logic [DATA_W-1:0] read_word,
  output logic [ADDR_W-1:0] addr_q,
  output logic [DATA_W-1:0] din_q,
  output logic we_q
);
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] din;
    logic we;
    logic [DATA_W-1:0] q;
  } port_t;

  port_t s;
  port_t next_s;

  always_comb begin
    next_s = s;
    next_s.we = ce & we;
    if (ce) begin
      next_s.addr = addr;
      next_s.din = din;
    end
    // sync reset only clears when enabled, so it needs no ordering
    if (ce && out_reg_en) begin
      next_s.q = sync_reset ? '0 : read_word;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dout = out_reg_en ? s.q : read_word;
  assign addr_q = s.addr;
  assign din_q = s.din;
  assign we_q = s.we;
endmodule // ebm_port

// file: hdl/ebm_loader.sv
// preload sequencer that fills the array from the user flash store
module ebm_loader
  import ebm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic start,
  input wire logic zero_image,
  input wire logic [FLASH_AW-1:0] image_base,
  output logic busy,
  output logic done,
  // user flash store
  output logic flash_req,
  output logic [FLASH_AW-1:0] flash_addr,
  input wire logic flash_ack,
  input wire logic [LOAD_W-1:0] flash_rdata,
  // array write
  output logic load_we,
  output logic [IDX_W-1:0] load_base,
  output logic [LOAD_W-1:0] load_data
);
  typedef enum logic [1:0] {
    L_IDLE = 2'h0,
    L_FETCH = 2'h1,
    L_WRITE = 2'h2
  } load_state_t;

  typedef struct packed {
    load_state_t st;
    logic [LOAD_IDX_W-1:0] idx;
    logic [LOAD_W-1:0] data;
    logic req;
    logic zero;
    logic done;
  } loader_t;

  loader_t s;
  loader_t next_s;

  always_comb begin
    next_s = s;
    unique case (s.st)
      L_IDLE: begin
        if (start) begin
          next_s.idx = '0;
          next_s.done = 1'b0;
          next_s.zero = zero_image;
          next_s.data = '0;
          next_s.req = ~zero_image;
          next_s.st = zero_image ? L_WRITE : L_FETCH;
        end
      end
      L_FETCH: begin
        if (flash_ack) begin
          next_s.data = flash_rdata;
          next_s.req = 1'b0;
          next_s.st = L_WRITE;
        end
      end
      L_WRITE: begin
        if (s.idx == LOAD_LAST) begin
          next_s.st = L_IDLE;
          next_s.done = 1'b1;
        end else begin
          next_s.idx = s.idx + 1'b1;
          next_s.req = ~s.zero;
          next_s.st = s.zero ? L_WRITE : L_FETCH;
        end
      end
      default: next_s.st = L_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // same base, same flash words: one stored copy serves every instance
  assign flash_addr = image_base + FLASH_AW'(s.idx);
  assign flash_req = s.req;
  assign busy = s.st != L_IDLE;
  assign done = s.done;
  assign load_we = s.st == L_WRITE;
  assign load_base = {s.idx, 4'h0};
  assign load_data = s.data;
endmodule // ebm_loader

// file: hdl/embedded_block_memory.sv
// embedded block memory: ram, rom and fifo modes over one bit array
module embedded_block_memory
  import ebm_pkg::*;
(
  // clock and system reset
  input wire logic clk,
  input wire logic reset,

  // register port
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [REG_DW-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [REG_DW-1:0] reg_rdata,

  // memory resets
  input wire logic mem_async_reset,
  input wire logic global_set_reset,
  input wire logic sync_reset,
  input wire logic fifo_full_reset,
  input wire logic read_pointer_clear,

  // port a
  input wire logic ce_a,
  input wire logic we_a,
  input wire logic [ADDR_W-1:0] addr_a,
  input wire logic [DATA_W-1:0] din_a,
  output logic [DATA_W-1:0] dout_a,

  // port b
  input wire logic ce_b,
  input wire logic we_b,
  input wire logic [ADDR_W-1:0] addr_b,
  input wire logic [DATA_W-1:0] din_b,
  output logic [DATA_W-1:0] dout_b,

  // fifo
  input wire logic fifo_wr_en,
  input wire logic fifo_rd_en,
  output logic [DATA_W-1:0] fifo_dout,
  output logic fifo_full,
  output logic fifo_empty,

  // user flash store
  output logic flash_req,
  output logic [FLASH_AW-1:0] flash_addr,
  input wire logic flash_ack,
  input wire logic [LOAD_W-1:0] flash_rdata
);
  typedef struct packed {
    mode_t mode;
    logic [2:0] width_a;
    logic [2:0] width_b;
    logic oreg_a;
    logic oreg_b;
    logic gsr_en;
    logic zero_image;
    logic [FLASH_AW-1:0] image_base;
    logic start;
    logic [REG_DW-1:0] rdata;
  } cfg_t;

  typedef struct packed {
    logic [IDX_W-1:0] ptr;
    logic wrap;
  } wside_t;

  typedef struct packed {
    logic [IDX_W-1:0] ptr;
    logic wrap;
    logic [DATA_W-1:0] q;
  } rside_t;

  cfg_t cfg;
  cfg_t next_cfg;
  wside_t ws;
  wside_t next_ws;
  rside_t rs;
  rside_t next_rs;
  logic [MEM_BITS-1:0] mem;
  logic [MEM_BITS-1:0] next_mem;

  logic gsr_eff;
  logic core_rst;
  logic wside_rst;
  logic rside_rst;

  logic [4:0] wa_w;
  logic [4:0] wb_w;
  logic [IDX_W-1:0] cap;

  logic [IDX_W-1:0] level;
  logic full;
  logic empty;

  logic cfg_err;
  logic busy;
  logic done;

  logic ram_mode;
  logic wr_ok;
  logic fifo_push;
  logic fifo_pop;
  logic [IDX_W:0] w_next;
  logic [IDX_W:0] r_next;

  logic [ADDR_W-1:0] addr_a_q;
  logic [ADDR_W-1:0] addr_b_q;
  logic [DATA_W-1:0] din_a_q;
  logic [DATA_W-1:0] din_b_q;
  logic we_a_q;
  logic we_b_q;

  logic [DATA_W-1:0] rd_a;
  logic [DATA_W-1:0] rd_b;

  logic load_we;
  logic [IDX_W-1:0] load_base;
  logic [LOAD_W-1:0] load_data;

  logic [REG_DW-1:0] ctrl_word;
  logic [REG_DW-1:0] width_word;
  logic [REG_DW-1:0] status_word;

  // reset trees; all act without the clock, user keeps enables quiet around them
  assign gsr_eff = global_set_reset & (cfg.gsr_en | (cfg.mode == MODE_FIFO));

  assign core_rst = reset | mem_async_reset | gsr_eff;

  assign wside_rst = core_rst | fifo_full_reset;
  assign rside_rst = wside_rst | read_pointer_clear;

  // geometry
  assign wa_w = width_of(cfg.width_a);
  assign wb_w = width_of(cfg.width_b);
  assign cap = (cfg.width_a >= WC_X9 && cfg.width_b >= WC_X9) ? MEM_LIM : CAP_POW2;

  assign cfg_err = ~legal(cfg.mode, cfg.width_a) | ~legal(cfg.mode, cfg.width_b);

  // mode gating; rom leaves the port and fifo write paths off, preload still writes
  assign ram_mode = cfg.mode == MODE_SP || cfg.mode == MODE_TDP || cfg.mode == MODE_PDP;

  assign wr_ok = ~cfg_err & ~busy;

  // fifo level from pointers; wrap bits tell full from empty
  assign level = (ws.wrap == rs.wrap) ? ws.ptr - rs.ptr : cap - rs.ptr + ws.ptr;
  assign full = ({1'b0, level} + (IDX_W + 1)'(wa_w)) > {1'b0, cap};
  assign empty = level < IDX_W'(wb_w);

  // enables act as clock enables for this mode
  assign fifo_push = cfg.mode == MODE_FIFO && fifo_wr_en && !full && wr_ok;
  assign fifo_pop = cfg.mode == MODE_FIFO && fifo_rd_en && !empty && !busy;

  assign w_next = advance(ws.ptr, wa_w, cap);
  assign r_next = advance(rs.ptr, wb_w, cap);

  // register file
  always_comb begin
    ctrl_word = '0;
    ctrl_word[CTRL_MODE_LSB +: 3] = cfg.mode;
    ctrl_word[CTRL_OREG_A] = cfg.oreg_a;
    ctrl_word[CTRL_OREG_B] = cfg.oreg_b;
    ctrl_word[CTRL_GSR_EN] = cfg.gsr_en;
    ctrl_word[CTRL_ZERO] = cfg.zero_image;

    width_word = '0;
    width_word[WIDTH_A_LSB +: 3] = cfg.width_a;
    width_word[WIDTH_B_LSB +: 3] = cfg.width_b;

    status_word = '0;
    status_word[ST_BUSY] = busy;
    status_word[ST_DONE] = done;
    status_word[ST_CFG_ERR] = cfg_err;
    status_word[ST_FULL] = full;
    status_word[ST_EMPTY] = empty;
  end

  always_comb begin
    next_cfg = cfg;
    next_cfg.start = 1'b0;
    if (reg_write) begin
      case (reg_addr)
        REG_CTRL: begin
          next_cfg.mode = mode_t'(reg_wdata[CTRL_MODE_LSB +: 3]);
          next_cfg.oreg_a = reg_wdata[CTRL_OREG_A];
          next_cfg.oreg_b = reg_wdata[CTRL_OREG_B];
          next_cfg.gsr_en = reg_wdata[CTRL_GSR_EN];
          next_cfg.zero_image = reg_wdata[CTRL_ZERO];
        end
        REG_WIDTH: begin
          next_cfg.width_a = reg_wdata[WIDTH_A_LSB +: 3];
          next_cfg.width_b = reg_wdata[WIDTH_B_LSB +: 3];
        end
        REG_IMAGE: next_cfg.image_base = reg_wdata;
        REG_START: next_cfg.start = reg_wdata[START_GO];
        default: next_cfg.start = 1'b0;
      endcase
    end

    // unmapped offsets read as zero
    if (reg_read) begin
      case (reg_addr)
        REG_CTRL: next_cfg.rdata = ctrl_word;
        REG_WIDTH: next_cfg.rdata = width_word;
        REG_IMAGE: next_cfg.rdata = cfg.image_base;
        REG_STATUS: next_cfg.rdata = status_word;
        REG_LEVEL: next_cfg.rdata = REG_DW'(level);
        default: next_cfg.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg <= '0;
      cfg.mode <= mode_t'(CTRL_RESET[CTRL_MODE_LSB +: 3]);
      cfg.width_a <= WIDTH_RESET[WIDTH_A_LSB +: 3];
      cfg.width_b <= WIDTH_RESET[WIDTH_B_LSB +: 3];
      cfg.image_base <= IMAGE_RESET;
    end else begin
      cfg <= next_cfg;
    end
  end

  assign reg_rdata = cfg.rdata;

  // fifo write side
  always_comb begin
    next_ws = ws;
    if (fifo_push) begin
      next_ws.ptr = w_next[IDX_W-1:0];
      next_ws.wrap = ws.wrap ^ w_next[IDX_W];
    end
  end

  always_ff @(posedge clk or posedge wside_rst) begin
    if (wside_rst) begin
      ws <= '0;
    end else begin
      ws <= next_ws;
    end
  end

  // fifo read side; pointer clear rewinds reads and zeroes fifo_dout, stored data untouched
  always_comb begin
    next_rs = rs;
    if (fifo_pop) begin
      next_rs.q = read_bits(mem, rs.ptr, wb_w, cap);
      next_rs.ptr = r_next[IDX_W-1:0];
      next_rs.wrap = rs.wrap ^ r_next[IDX_W];
    end
  end

  always_ff @(posedge clk or posedge rside_rst) begin
    if (rside_rst) begin
      rs <= '0;
    end else begin
      rs <= next_rs;
    end
  end

  assign fifo_dout = rs.q;
  assign fifo_full = full;
  assign fifo_empty = empty;

  // array writes; loader has priority, port b wins a same-bit clash
  always_comb begin
    next_mem = mem;
    if (load_we) begin
      next_mem = write_bits(mem, load_base, DATA_W'(load_data), LOAD_BITS, MEM_LIM);
    end else if (fifo_push) begin
      next_mem = write_bits(mem, ws.ptr, din_a, wa_w, cap);
    end else if (ram_mode && wr_ok) begin
      if (we_a_q) begin
        next_mem = write_bits(next_mem, bit_base(addr_a_q, cfg.width_a), din_a_q, wa_w,
                              MEM_LIM);
      end

      if (we_b_q && cfg.mode == MODE_TDP) begin
        next_mem = write_bits(next_mem, bit_base(addr_b_q, cfg.width_b), din_b_q, wb_w,
                              MEM_LIM);
      end
    end
  end

  // no reset here: contents survive every reset
  always_ff @(posedge clk) begin
    mem <= next_mem;
  end

  // read paths share the one linear layout
  assign rd_a = read_bits(mem, bit_base(addr_a_q, cfg.width_a), wa_w, MEM_LIM);
  assign rd_b = read_bits(mem, bit_base(addr_b_q, cfg.width_b), wb_w, MEM_LIM);

  ebm_port port_a (
    .clk(clk),
    .reset(core_rst),
    .sync_reset(sync_reset),
    .ce(ce_a),
    .we(we_a),
    .addr(addr_a),
    .din(din_a),
    .dout(dout_a),
    .out_reg_en(cfg.oreg_a),
    .read_word(rd_a),
    .addr_q(addr_a_q),
    .din_q(din_a_q),
    .we_q(we_a_q)
  );

  ebm_port port_b (
    .clk(clk),
    .reset(core_rst),
    .sync_reset(sync_reset),
    .ce(ce_b),
    .we(we_b),
    .addr(addr_b),
    .din(din_b),
    .dout(dout_b),
    .out_reg_en(cfg.oreg_b),
    .read_word(rd_b),
    .addr_q(addr_b_q),
    .din_q(din_b_q),
    .we_q(we_b_q)
  );

  // preload runs on the system reset only, so a memory reset cannot cut it short
  ebm_loader loader (
    .clk(clk),
    .reset(reset),
    .start(cfg.start),
    .zero_image(cfg.zero_image),
    .image_base(cfg.image_base),
    .busy(busy),
    .done(done),
    .flash_req(flash_req),
    .flash_addr(flash_addr),
    .flash_ack(flash_ack),
    .flash_rdata(flash_rdata),
    .load_we(load_we),
    .load_base(load_base),
    .load_data(load_data)
  );
endmodule // embedded_block_memory

// file: tb/ebm_asserts.sv
// checker for the block memory top ports
module ebm_asserts
  import ebm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [REG_DW-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [REG_DW-1:0] reg_rdata,
  // resets
  input wire logic mem_async_reset,
  input wire logic global_set_reset,
  input wire logic fifo_full_reset,
  input wire logic read_pointer_clear,
  // fifo and flash
  input wire logic [DATA_W-1:0] fifo_dout,
  input wire logic fifo_full,
  input wire logic fifo_empty,
  input wire logic flash_req,
  input wire logic [FLASH_AW-1:0] flash_addr,
  input wire logic flash_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [REG_DW-1:0] ctrl;
  logic [REG_DW-1:0] width;
  logic odd_shape;
  logic gsr_on;
  // shadows land one edge after the write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl <= CTRL_RESET;
      width <= WIDTH_RESET;
    end else if (reg_write && reg_addr == REG_CTRL) begin
      ctrl <= reg_wdata;
    end else if (reg_write && reg_addr == REG_WIDTH) begin
      width <= reg_wdata;
    end
  end
  assign odd_shape = ctrl[2:1] == 2'h0 && (width[2:0] == WC_X18 || width[6:4] == WC_X18);
  assign gsr_on = ctrl[2:0] == MODE_FIFO || ctrl[CTRL_GSR_EN];
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  req_hold_a: assert property (flash_req && !flash_ack |=> flash_req)
    else $error("flash request dropped early");
  addr_steady_a: assert property (flash_req && !flash_ack |=> $stable(flash_addr))
    else $error("flash address moved mid request");
  ack_gap_a: assert property (flash_ack |=> !flash_req)
    else $error("flash request kept after ack");
  zero_quiet_a: assert property (ctrl[CTRL_ZERO] |-> !flash_req)
    else $error("flash read for zero image");
  full_clear_a: assert property (
    fifo_full_reset |-> fifo_empty && !fifo_full && fifo_dout == '0)
    else $error("full reset left fifo state");
  rp_clear_a: assert property (read_pointer_clear |-> fifo_dout == '0)
    else $error("pointer clear left fifo data");
  gsr_clear_a: assert property (
    global_set_reset && gsr_on |-> fifo_empty && !fifo_full)
    else $error("set reset ignored");
  mem_clear_a: assert property (mem_async_reset |-> fifo_empty && !fifo_full)
    else $error("memory reset left fifo pointers");
  shape_err_a: assert property (
    reg_read && reg_addr == REG_STATUS && odd_shape && $past(odd_shape)
    |=> reg_rdata[ST_CFG_ERR])
    else $error("illegal shape not flagged");
  cover property (flash_ack);
  cover property (read_pointer_clear);
  cover property (reg_read && odd_shape);
endmodule // ebm_asserts

bind embedded_block_memory ebm_asserts chk (.clk, .reset, .reg_addr, .reg_wdata, .reg_write,
  .reg_read, .reg_rdata, .mem_async_reset, .global_set_reset, .fifo_full_reset,
  .read_pointer_clear, .fifo_dout, .fifo_full, .fifo_empty, .flash_req, .flash_addr,
  .flash_ack);

// file: tb/flash_model.sv
// flash store model answering preload word requests
module flash_model
  import ebm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // request side
  input wire logic flash_req,
  input wire logic [FLASH_AW-1:0] flash_addr,
  output logic flash_ack,
  output logic [LOAD_W-1:0] flash_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_n;
  // odd words answer slowly; data scrambles once released
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      wait_n <= 0;
      flash_ack <= 1'h0;
      flash_rdata <= 16'h0000;
    end else if (flash_req && !flash_ack && wait_n < (flash_addr[0] ? 3 : 0)) begin
      wait_n <= wait_n + 1;
      flash_rdata <= ~flash_rdata;
    end else if (flash_req && !flash_ack) begin
      wait_n <= 0;
      flash_ack <= 1'h1;
      flash_rdata <= flash_addr ^ 16'ha5c3;
    end else begin
      flash_ack <= 1'h0;
      flash_rdata <= ~flash_rdata;
    end
  end
endmodule // flash_model

// file: tb/testbench.sv
// self-checking bench for the block memory
module testbench
  import ebm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // clock, reset and register port
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic [REG_AW-1:0] reg_addr = '0;
  logic [REG_DW-1:0] reg_wdata = '0;
  logic reg_write = 1'h0;
  logic reg_read = 1'h0;
  logic [REG_DW-1:0] reg_rdata;
  // memory resets
  logic mem_async_reset = 1'h0;
  logic global_set_reset = 1'h0;
  logic sync_reset = 1'h0;
  logic fifo_full_reset = 1'h0;
  logic read_pointer_clear = 1'h0;
  // ports, fifo and flash
  logic ce_a = 1'h0;
  logic we_a = 1'h0;
  logic ce_b = 1'h0;
  logic we_b = 1'h0;
  logic [ADDR_W-1:0] addr_a = '0;
  logic [ADDR_W-1:0] addr_b = '0;
  logic [DATA_W-1:0] din_a = '0;
  logic [DATA_W-1:0] din_b = '0;
  logic [DATA_W-1:0] dout_a;
  logic [DATA_W-1:0] dout_b;
  logic fifo_wr_en = 1'h0;
  logic fifo_rd_en = 1'h0;
  logic [DATA_W-1:0] fifo_dout;
  logic fifo_full;
  logic fifo_empty;
  logic flash_req;
  logic [FLASH_AW-1:0] flash_addr;
  logic flash_ack;
  logic [LOAD_W-1:0] flash_rdata;
  int errors = 0;
  int checks_done = 0;
  logic mdl [0:MEM_BITS-1];
  logic [3:0] hist [$];
  logic [REG_AW-1:0] rst_regs [5] = '{REG_CTRL, REG_WIDTH, REG_IMAGE, 3'h6, 3'h7};

  embedded_block_memory DUT (.clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .mem_async_reset, .global_set_reset, .sync_reset, .fifo_full_reset,
    .read_pointer_clear, .ce_a, .we_a, .addr_a, .din_a, .dout_a, .ce_b, .we_b, .addr_b,
    .din_b, .dout_b, .fifo_wr_en, .fifo_rd_en, .fifo_dout, .fifo_full, .fifo_empty,
    .flash_req, .flash_addr, .flash_ack, .flash_rdata);
  flash_model flash (.clk, .reset, .flash_req, .flash_addr, .flash_ack, .flash_rdata);

  always #12.5 clk = ~clk;

  task check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task wr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
    @(posedge clk);
    reg_write <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'h0;
  endtask

  task rd(input logic [REG_AW-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_read <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'h0;
    #1 d = DATA_W'(reg_rdata);
  endtask

  task pwr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    ce_a <= 1'h1;
    we_a <= 1'h1;
    addr_a <= a;
    din_a <= d;
    @(posedge clk);
    ce_a <= 1'h0;
    we_a <= 1'h0;
  endtask

  // output register needs ce one more edge
  task prd(input logic pb, input logic oreg, input logic [ADDR_W-1:0] a,
           output logic [DATA_W-1:0] d);
    @(posedge clk);
    if (pb) begin
      ce_b <= 1'h1;
      addr_b <= a;
    end else begin
      ce_a <= 1'h1;
      addr_a <= a;
    end
    @(posedge clk);
    if (oreg) @(posedge clk);
    ce_a <= 1'h0;
    ce_b <= 1'h0;
    #1 d = pb ? dout_b : dout_a;
  endtask

  task fop(input logic pop, input logic [3:0] v, output logic [DATA_W-1:0] d);
    @(posedge clk);
    if (pop) fifo_rd_en <= 1'h1;
    else begin
      fifo_wr_en <= 1'h1;
      din_a <= DATA_W'(v);
    end
    @(posedge clk);
    fifo_rd_en <= 1'h0;
    fifo_wr_en <= 1'h0;
    #1 d = fifo_dout;
  endtask

  // enables stay low a cycle around each pulse
  task pulse(input int which);
    @(posedge clk);
    @(posedge clk);
    case (which)
      0: mem_async_reset <= 1'h1;
      1: global_set_reset <= 1'h1;
      2: fifo_full_reset <= 1'h1;
      default: read_pointer_clear <= 1'h1;
    endcase
    @(posedge clk);
    @(posedge clk);
    {mem_async_reset, global_set_reset, fifo_full_reset, read_pointer_clear} <= 4'h0;
    @(posedge clk);
  endtask

  task load;
    logic [DATA_W-1:0] s;
    wr(REG_START, 16'h0001);
    repeat (3) @(posedge clk);
    for (int i = 0; i < 2000; i++) begin
      rd(REG_STATUS, s);
      if (s[ST_DONE] === 1'h1 && s[ST_BUSY] === 1'h0) return;
    end
    errors++;
    print_verdict();
  endtask

  initial begin
    logic [DATA_W-1:0] d;
    logic [FLASH_AW-1:0] base;
    int k;
    int n;
    void'($urandom(32'hbb5d_bf34));
    repeat (16) @(posedge clk);
    reset <= 1'h0;
    foreach (rst_regs[i]) begin
      rd(rst_regs[i], d);
      check(d, '0);
    end
    $display("test reset values done");
    base = FLASH_AW'($urandom);
    wr(REG_WIDTH, 16'h0002);
    wr(REG_IMAGE, base);
    wr(REG_CTRL, 16'h0003);
    load();
    for (int i = 0; i < 8; i++) begin
      k = $urandom_range(0, LOAD_WORDS * 4 - 1);
      prd(1'h0, 1'h0, ADDR_W'(k), d);
      check(d, DATA_W'(((16'(base + k / 4) ^ 16'ha5c3) >> (4 * (k % 4))) & 16'h000f));
    end
    wr(REG_CTRL, 16'h0040);
    load();
    foreach (mdl[i]) mdl[i] = 1'h0;
    prd(1'h0, 1'h0, ADDR_W'($urandom_range(0, 2047)), d);
    check(d, '0);
    $display("test preload done");
    wr(REG_CTRL, 16'h0001);
    wr(REG_WIDTH, 16'h0001);
    for (int i = 0; i < 16; i++) begin
      n = $urandom_range(0, 3);
      pwr(ADDR_W'(i), DATA_W'(n));
      mdl[2 * i] = n[0];
      mdl[2 * i + 1] = n[1];
    end
    for (int i = 0; i < 8; i++) begin
      k = $urandom_range(0, 31);
      prd(1'h1, 1'h0, ADDR_W'(k), d);
      check(d, DATA_W'(mdl[k]));
    end
    wr(REG_CTRL, 16'h0011);
    wr(REG_WIDTH, 16'h0021);
    pulse(0);
    for (int i = 0; i < 8; i++) begin
      prd(1'h1, 1'h1, ADDR_W'(i), d);
      check(d, DATA_W'({mdl[4 * i + 3], mdl[4 * i + 2], mdl[4 * i + 1], mdl[4 * i]}));
    end
    sync_reset <= 1'h1;
    prd(1'h1, 1'h1, ADDR_W'(1), d);
    sync_reset <= 1'h0;
    check(d, '0);
    $display("test ram ports done");
    wr(REG_CTRL, 16'h0000);
    wr(REG_WIDTH, 16'h0004);
    rd(REG_STATUS, d);
    check(DATA_W'(d[ST_CFG_ERR]), DATA_W'(1'h1));
    wr(REG_CTRL, 16'h0002);
    rd(REG_STATUS, d);
    check(DATA_W'(d[ST_CFG_ERR]), DATA_W'(1'h0));
    $display("test shapes done");
    wr(REG_CTRL, 16'h0004);
    wr(REG_WIDTH, 16'h0022);
    repeat (5) begin
      n = $urandom_range(0, 15);
      fop(1'h0, 4'(n), d);
      hist.push_back(4'(n));
    end
    for (int i = 0; i < 4; i++) begin
      fop(1'h1, 4'h0, d);
      check(d, DATA_W'(hist[i]));
    end
    pulse(3);
    fop(1'h1, 4'h0, d);
    check(d, DATA_W'(hist[0]));
    pulse(2);
    rd(REG_STATUS, d);
    check(DATA_W'(d[ST_EMPTY]), DATA_W'(1'h1));
    fop(1'h0, 4'h5, d);
    pulse(1);
    rd(REG_STATUS, d);
    check(DATA_W'(d[ST_EMPTY]), DATA_W'(1'h1));
    $display("test fifo done");
    print_verdict();
  end
endmodule // testbench
